// >>> hvid_defs.svh
// Constants for the host version and id ROM access block.
// Included by the package, hvid_top and the bench; definitions only.
`ifndef HVID_DEFS_SVH
`define HVID_DEFS_SVH

`define HVID_REG_AW          8
`define HVID_OFF_VERSION     8'h00
`define HVID_OFF_ROM_ACCESS  8'h04

`define HVID_VER_MAJOR       8'h01
`define HVID_VER_MINOR       8'h10

`define HVID_BIT_PTR_CLR     31
`define HVID_BIT_PRESENT     24
`define HVID_BIT_READ_GO     25
`define HVID_FLD_HI_MSB      23
`define HVID_FLD_HI_LSB      16
`define HVID_FLD_LO_MSB      7
`define HVID_FLD_LO_LSB      0

`define HVID_OPT_ROM_ADDR    8'h28
`define HVID_OPT_ROM_RESET   8'h00
`define HVID_SETTLE_LAST     2'h3

`endif

// >>> hvid_pkg.sv
// Types for the host version and id ROM access block.
// Assumes hvid_defs.svh sits in the include path.
`include "hvid_defs.svh"

package hvid_pkg;

	typedef enum logic [4:0] {
		HVID_ST_SETTLE = 5'h01,
		HVID_ST_BOOT   = 5'h02,
		HVID_ST_OPT    = 5'h04,
		HVID_ST_IDLE   = 5'h08,
		HVID_ST_READ   = 5'h10
	} hvid_state_t;

	// Byte request toward the EEPROM engine
	typedef struct packed {
		logic       req;
		logic [7:0] addr;
	} hvid_ee_req_t;

	typedef struct packed {
		hvid_state_t  st;
		logic [1:0]   settle;
		logic [1:0]   det_sync;
		logic         present;
		logic         clr_pend;
		logic         go_pend;
		logic [7:0]   ptr;
		logic [7:0]   byte_val;
		logic [7:0]   opt_off;
		logic [7:0]   boot_idx;
		hvid_ee_req_t ee;
		logic [31:0]  rdata;
	} hvid_regs_t;

endpackage

// >>> hvid_bib_mem.sv
// Small byte memory holding the bus information block copy.
// Written during boot load; read by the link side, data registered.
`timescale 1ns/1ps

module hvid_bib_mem
	import hvid_pkg::*;
#(
	parameter int DEPTH = 20,
	parameter int AW    = 5
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// >>> hvid_top.sv
// Version register and EEPROM byte access register with boot load.
// Assumes a same-clock EEPROM byte engine; detect pin is asynchronous.
// rst_b is the global reset pin; soft_rst is a synchronous lesser reset.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

`include "hvid_defs.svh"

module hvid_top
	import hvid_pkg::*;
#(
	parameter int BIB_BYTES = 20,
	parameter int BIB_AW    = 5,
	parameter int BIB_BASE  = 0
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    soft_rst,
	input  wire logic [`HVID_REG_AW-1:0] reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata,
	input  wire logic                    eeprom_detect,
	output hvid_ee_req_t                 ee_cmd,
	input  wire logic                    ee_ack,
	input  wire logic [7:0]              ee_rd_data,
	output logic                         eeprom_present_flag,
	output logic      [7:0]              option_rom_offset,
	input  wire logic [BIB_AW-1:0]       bib_rd_addr,
	output logic      [7:0]              bib_rd_data
);

	hvid_regs_t         s;
	hvid_regs_t         n;
	logic               mem_we;
	logic [BIB_AW-1:0]  mem_wa;
	logic               wr_access;

	function automatic logic [31:0] reg_word(
		input logic [`HVID_REG_AW-1:0] a,
		input hvid_regs_t              r
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == `HVID_OFF_VERSION) begin
			w[`HVID_BIT_PRESENT] = r.present;
			w[`HVID_FLD_HI_MSB:`HVID_FLD_HI_LSB] = `HVID_VER_MAJOR;
			w[`HVID_FLD_LO_MSB:`HVID_FLD_LO_LSB] = `HVID_VER_MINOR;
		end else if (a == `HVID_OFF_ROM_ACCESS) begin
			w[`HVID_BIT_PTR_CLR] = r.clr_pend;
			w[`HVID_BIT_READ_GO] = r.go_pend;
			w[`HVID_FLD_HI_MSB:`HVID_FLD_HI_LSB] = r.byte_val;
			w[`HVID_FLD_LO_MSB:`HVID_FLD_LO_LSB] = r.opt_off;
		end
		return w;
	endfunction

	assign wr_access = reg_wr && (reg_addr == `HVID_OFF_ROM_ACCESS);

	always_comb begin
		n = s;
		mem_we = 1'b0;
		mem_wa = s.boot_idx[BIB_AW-1:0];
		n.det_sync = {s.det_sync[0], eeprom_detect};
		if (s.det_sync[1]) begin
			n.present = 1'b1;
		end
		n.rdata = reg_rd ? reg_word(reg_addr, s) : 32'h0000_0000;

		unique case (s.st)
			HVID_ST_SETTLE: begin
				n.settle = s.settle + 2'h1;
				if (s.settle == `HVID_SETTLE_LAST) begin
					if (s.present) begin
						n.st = HVID_ST_BOOT;
						n.ee.req = 1'b1;
						n.ee.addr = 8'(BIB_BASE);
					end else begin
						n.st = HVID_ST_IDLE;
					end
				end
			end
			HVID_ST_BOOT: begin
				if (ee_ack) begin
					mem_we = 1'b1;
					n.boot_idx = s.boot_idx + 8'h01;
					n.ee.addr = 8'(BIB_BASE) + n.boot_idx;
					if (s.boot_idx == 8'(BIB_BYTES - 1)) begin
						n.st = HVID_ST_OPT;
						n.ee.addr = `HVID_OPT_ROM_ADDR;
					end
				end
			end
			HVID_ST_OPT: begin
				if (ee_ack) begin
					n.opt_off = ee_rd_data;
					n.ee.req = 1'b0;
					n.st = HVID_ST_IDLE;
				end
			end
			HVID_ST_IDLE: begin
				if (s.clr_pend) begin
					n.ptr = 8'h00;
					n.clr_pend = 1'b0;
				end else if (s.go_pend) begin
					n.st = HVID_ST_READ;
					n.ee.req = 1'b1;
					n.ee.addr = s.ptr;
				end
			end
			HVID_ST_READ: begin
				if (ee_ack) begin
					n.go_pend = 1'b0;
					n.byte_val = ee_rd_data;
					n.ptr = s.ptr + 8'h01;
					n.ee.req = 1'b0;
					n.st = HVID_ST_IDLE;
				end
			end
		endcase

		if (wr_access && s.present && s.st == HVID_ST_IDLE
				&& !s.clr_pend && !s.go_pend) begin
			if (reg_wdata[`HVID_BIT_PTR_CLR]) begin
				n.clr_pend = 1'b1;
			end else if (reg_wdata[`HVID_BIT_READ_GO]) begin
				n.go_pend = 1'b1;
			end
		end

		if (soft_rst) begin
			n.clr_pend = 1'b0;
			n.go_pend = 1'b0;
			n.ptr = 8'h00;
			n.byte_val = 8'h00;
			if (s.st == HVID_ST_READ) begin
				n.st = HVID_ST_IDLE;
				n.ee.req = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s.st <= HVID_ST_SETTLE;
			s.settle <= 2'h0;
			s.det_sync <= 2'h0;
			s.present <= 1'b0;
			s.clr_pend <= 1'b0;
			s.go_pend <= 1'b0;
			s.ptr <= 8'h00;
			s.byte_val <= 8'h00;
			s.opt_off <= `HVID_OPT_ROM_RESET;
			s.boot_idx <= 8'h00;
			s.ee <= '0;
			s.rdata <= 32'h0000_0000;
		end else begin
			s <= n;
		end
	end

	hvid_bib_mem #(
		.DEPTH (BIB_BYTES),
		.AW    (BIB_AW)
	) u_bib_mem (
		.clk     (clk),
		.rst_b   (rst_b),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (ee_rd_data),
		.rd_addr (bib_rd_addr),
		.rd_data (bib_rd_data)
	);

	assign reg_rdata = s.rdata;
	assign ee_cmd = s.ee;
	assign eeprom_present_flag = s.present;
	assign option_rom_offset = s.opt_off;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	ver_reserved_zero_a:
	assert property (reg_rd && reg_addr == `HVID_OFF_VERSION |=>
		reg_rdata[31:25] == 7'h00 && reg_rdata[15:8] == 8'h00)
		else $error("version reserved bits not zero");

	presence_sticky_a:
	assert property (s.present |=> s.present)
		else $error("presence flag dropped without global reset");

	presence_set_a:
	assert property (s.det_sync[1] |=> s.present)
		else $error("presence flag not set after detect");

	ver_major_a:
	assert property (reg_rd && reg_addr == `HVID_OFF_VERSION |=>
		reg_rdata[23:16] == 8'h01)
		else $error("major version wrong");

	ver_minor_a:
	assert property (reg_rd && reg_addr == `HVID_OFF_VERSION |=>
		reg_rdata[7:0] == 8'h10 && reg_rdata[24] == $past(s.present))
		else $error("minor version or presence bit wrong");

	boot_start_a:
	assert property (s.st == HVID_ST_SETTLE && s.settle == 2'h3
		&& s.present |=> s.st == HVID_ST_BOOT && ee_cmd.req)
		else $error("boot load not started");

	ptr_clear_done_a:
	assert property (s.clr_pend && s.st == HVID_ST_IDLE |=>
		!s.clr_pend && s.ptr == 8'h00)
		else $error("pointer clear not finished in one cycle");

	no_auto_fetch_a:
	assert property (s.clr_pend && !soft_rst |=>
		s.byte_val == $past(s.byte_val) && !ee_cmd.req)
		else $error("byte fetched after pointer clear");

	read_done_a:
	assert property (s.st == HVID_ST_READ && ee_ack && !soft_rst |=>
		!s.go_pend && s.byte_val == $past(ee_rd_data)
		&& s.ptr == $past(s.ptr) + 8'h01)
		else $error("byte read completion wrong");

	acc_reserved_zero_a:
	assert property (reg_rd && reg_addr == `HVID_OFF_ROM_ACCESS |=>
		reg_rdata[30:26] == 5'h00 && reg_rdata[24] == 1'b0
		&& reg_rdata[15:8] == 8'h00)
		else $error("access reserved bits not zero");

	opt_load_a:
	assert property (s.st == HVID_ST_OPT && ee_ack |=>
		option_rom_offset == $past(ee_rd_data) && s.st == HVID_ST_IDLE)
		else $error("option ROM offset not loaded");

	busy_ignore_a:
	assert property (s.go_pend && wr_access && !ee_ack
		&& !soft_rst |=> !s.clr_pend && s.go_pend)
		else $error("request taken while read pending");

	read_start_a:
	assert property (s.st == HVID_ST_IDLE && s.go_pend && !s.clr_pend
		&& !soft_rst |=> s.st == HVID_ST_READ && ee_cmd.req
		&& ee_cmd.addr == $past(s.ptr))
		else $error("byte read not started from pointer");

	acc_fields_a:
	assert property (reg_rd && reg_addr == `HVID_OFF_ROM_ACCESS |=>
		reg_rdata[`HVID_FLD_HI_MSB:`HVID_FLD_HI_LSB]
			== $past(s.byte_val)
		&& reg_rdata[`HVID_FLD_LO_MSB:`HVID_FLD_LO_LSB]
			== $past(s.opt_off))
		else $error("access register fields wrong");

	present_guard_a:
	assert property (wr_access && !s.present |=>
		!s.clr_pend && !s.go_pend)
		else $error("access write taken without EEPROM");

	boot_step_a:
	assert property (s.st == HVID_ST_BOOT && ee_ack
		&& s.boot_idx != 8'(BIB_BYTES - 1) |=>
		ee_cmd.req && ee_cmd.addr == $past(ee_cmd.addr) + 8'h01)
		else $error("boot load address did not advance");

endmodule

// >>> hvid_ee_model.sv
// Behavioural EEPROM byte engine answering req/ack byte fetches.
// Assumes the block's clock; delay plus one idle cycles precede each ack.
`timescale 1ns/1ps

module hvid_ee_model
	import hvid_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  hvid_ee_req_t    ee_cmd,
	input  wire logic [3:0] delay,
	output logic            ee_ack,
	output logic      [7:0] ee_rd_data
);
	logic [3:0] cnt;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt        <= 4'h0;
			ee_ack     <= 1'b0;
			ee_rd_data <= 8'h5a;
		end else if (ee_cmd.req && !ee_ack && cnt == delay) begin
			cnt        <= 4'h0;
			ee_ack     <= 1'b1;
			ee_rd_data <= {ee_cmd.addr[3:0], ee_cmd.addr[7:4]} ^ 8'ha5;
		end else begin
			// Junk on the data line outside the ack cycle
			cnt        <= (ee_cmd.req && !ee_ack) ? cnt + 4'h1 : 4'h0;
			ee_ack     <= 1'b0;
			ee_rd_data <= ~ee_rd_data;
		end
	end
endmodule

// >>> hvid_top_tb.sv
// Self-checking bench for the version and ROM access registers.
// Assumes hvid_ee_model stands in for the EEPROM byte engine.
`timescale 1ns/1ps

`include "hvid_defs.svh"

module hvid_top_tb
	import hvid_pkg::*;
;
	localparam logic [31:0] VER = {7'h00, 1'b1, `HVID_VER_MAJOR,
		8'h00, `HVID_VER_MINOR};
	logic         clk, rst_b, soft_rst, reg_wr, reg_rd, eeprom_detect;
	logic         ee_ack, eeprom_present_flag;
	logic [7:0]   reg_addr, ee_rd_data, option_rom_offset, bib_rd_data, p;
	logic [31:0]  reg_wdata, reg_rdata, d;
	logic [4:0]   bib_rd_addr;
	logic [3:0]   dly;
	hvid_ee_req_t ee_cmd;
	int           mismatches, compares;

	hvid_top uut (.clk, .rst_b, .soft_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .eeprom_detect, .ee_cmd, .ee_ack, .ee_rd_data,
		.eeprom_present_flag, .option_rom_offset, .bib_rd_addr, .bib_rd_data);
	hvid_ee_model ee (.clk, .rst_b, .ee_cmd, .delay(dly), .ee_ack,
		.ee_rd_data);

	function automatic logic [7:0] romb(input logic [7:0] a);
		return {a[3:0], a[7:4]} ^ 8'ha5;
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// Poll the access register until bit b clears
	task automatic poll(input int b);
		int i;
		for (i = 0; i < 100; i++) begin
			rd(8'h04);
			if (d[b] === 1'b0)
				break;
		end
		chk(d[b], 1'b0);
	endtask

	task automatic rdbyte(input logic [7:0] a);
		wr(8'h04, 32'h0200_0000);
		poll(25);
		chk(d, {8'h00, romb(a), 8'h00, romb(8'h28)});
	endtask

	task automatic complete_run();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100000;
		mismatches++;
		complete_run();
	end

	initial begin
		int i;
		rst_b = 1'b0;
		soft_rst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		eeprom_detect = 1'b1;
		dly = 4'h1;
		bib_rd_addr = 5'h03;
		mismatches = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		// Boot load runs until the byte request drops
		for (i = 0; i < 3000 && !(i > 8 && !ee_cmd.req); i++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		rd(`HVID_OFF_VERSION);
		chk(d, VER);
		chk(option_rom_offset, romb(8'h28));
		chk(bib_rd_data, romb(8'h03));
		$display("test boot done");
		wr(8'h04, 32'h8000_0000);
		poll(31);
		for (p = 8'h00; p < 8'h03; p++)
			rdbyte(p);
		$display("test byte reads done");
		wr(8'h04, 32'h0200_0000);
		dly <= 4'h6;
		wr(8'h04, 32'h8000_0000);
		poll(25);
		chk(d, {8'h00, romb(8'h03), 8'h00, romb(8'h28)});
		rdbyte(8'h04);
		wr(8'h04, 32'h8000_0000);
		poll(31);
		chk(d[23:16], romb(8'h04));
		rdbyte(8'h00);
		$display("test pending and clear done");
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00);
		chk(d, VER);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08);
		chk(d, 32'h0);
		$display("test read-only done");
		@(posedge clk);
		soft_rst <= 1'b1;
		eeprom_detect <= 1'b0;
		@(posedge clk);
		soft_rst <= 1'b0;
		rd(8'h00);
		chk(d, VER);
		chk(eeprom_present_flag, 1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h00);
		chk(d, VER & ~32'h0100_0000);
		chk(option_rom_offset, 8'h00);
		wr(8'h04, 32'h0200_0000);
		rd(8'h04);
		chk(d, 32'h0);
		$display("test resets done");
		complete_run();
	end
endmodule
